// ### rtl/tpw_core.sv
// tpw_core: slow clock select, wake event gathering and standby pin behaviour
// assumes trickle/main resets and bus strobes are in the clk_sys domain; pins are async
`timescale 1ns/1ps
// Functional notes
// - bit 0 at 0xf0 flags slow clock absent; 0 present, 1 grounded
// - presence register reset only by trickle power-on reset
// - absent flag picks external slow clock or 14 MHz derived 32 kHz
// - without external clock, key, blink and tach stop on trickle power
// - wake logic stays active on trickle power; enabled events pull wake low
// - wake sources: ring indicators, keyboard, mouse, key logic, tachs, gpios
// - main-powered wake pins are inputs only on trickle power
// - fan pins are low outputs after main reset and hard reset
// - fan pins revert to plain non-inverting output when main power leaves
// - retained pin returns to basic function, keeps invert and buffer type; output enable off without main power
// - alt infrared pin is low output after every reset, never a wake input
// - infrared pins low without main power, then follow port 2 transmit once activated
// - three non-wake pins have no path into the wake logic
// - led logic and pins keep working on trickle power
// - wake registers live in trickle domain and survive main power loss
// - every bus register is 8 bits wide
// - bus decoding stops while main power is not valid
module tpw_core
    import tpw_pkg::*;
#(
    parameter int DIV_HALF = SLOW_DIV_HALF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic main_rst_b,
    input wire logic hard_rst_b,
    input wire logic main_power_valid,
    input wire logic fast_clk_tick,
    input wire logic slow_clock_input_pin,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic ring1_n,
    input wire logic ring2_n,
    input wire logic kbd_data,
    input wire logic mouse_data,
    input wire logic key_match,
    input wire logic fan_tach_edge,
    input wire logic gpio_wake_in,
    input wire logic retained_config_pin_in,
    input wire logic nonwake_pin_a_in,
    input wire logic nonwake_pin_b_in,
    input wire logic nonwake_pin_c_in,
    input wire logic fan_a_drive,
    input wire logic fan_b_drive,
    input wire logic retained_alt_drive,
    input wire logic retained_gpio_drive,
    input wire logic serial2_active,
    input wire logic serial2_txd,
    input wire logic led_one_on,
    input wire logic led_two_on,
    input wire logic led_blink,
    output logic slow_tick,
    output logic slow_functions_run,
    output logic wake_event_out_n_o,
    output logic wake_event_out_n_oe,
    output logic fan_control_pin_a,
    output logic fan_control_pin_b,
    output logic retained_config_pin_o,
    output logic retained_config_pin_oe,
    output logic alt_infrared_tx_pin,
    output logic primary_infrared_tx_pin,
    output logic led_pin_one,
    output logic led_pin_two
);
    // the divider counter is 16 bits wide
    if (DIV_HALF < 1 || DIV_HALF > 65536) begin : g_div_check
        $error("tpw_core: DIV_HALF out of range");
    end

    logic [7:0] presence_reg;
    logic [7:0] wake_enable_reg;
    logic [WAKE_SOURCES-1:0] wake_status_reg;
    logic [7:0] pin_config_reg;
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [WAKE_SOURCES-1:0] src_meta_reg;
    logic [WAKE_SOURCES-1:0] src_sync_reg;
    logic [WAKE_SOURCES-1:0] src_last_reg;
    logic [WAKE_SOURCES-1:0] src_rise;
    logic [WAKE_SOURCES-1:0] raw_src;
    logic [WAKE_SOURCES-1:0] status_clear;
    logic [15:0] div_cnt_reg;
    logic div_clk_reg;
    logic div_last_reg;
    logic bus_ok;
    logic absent;
    logic ext_tick;
    logic int_tick;
    logic blink_phase_reg;
    logic main_seen_reg;

    assign absent = presence_reg[ABSENT_BIT];
    assign bus_ok = main_power_valid;

    // register writes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            presence_reg <= PRESENCE_RESET;
        end else if (reg_wr && bus_ok && reg_addr == SLOW_CLOCK_PRESENCE_OFS) begin
            presence_reg <= {7'h00, reg_wdata[ABSENT_BIT]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wake_enable_reg <= WAKE_ENABLE_RESET;
            pin_config_reg <= PIN_CONFIG_RESET;
        end else if (reg_wr && bus_ok) begin
            if (reg_addr == WAKE_ENABLE_OFS) begin
                wake_enable_reg <= reg_wdata;
            end
            if (reg_addr == PIN_CONFIG_OFS) begin
                pin_config_reg <= {4'h0, reg_wdata[3:0]};
            end
        end
    end

    // read mux
    always_comb begin
        reg_rdata = 8'h00;
        if (reg_rd && bus_ok) begin
            unique case (reg_addr)
                SLOW_CLOCK_PRESENCE_OFS: reg_rdata = presence_reg;
                WAKE_STATUS_OFS: reg_rdata = wake_status_reg;
                WAKE_ENABLE_OFS: reg_rdata = wake_enable_reg;
                PIN_CONFIG_OFS: reg_rdata = pin_config_reg;
                default: reg_rdata = 8'h00;
            endcase
        end
    end

    // synchronisers: pins and slow clock
    assign raw_src[SRC_RI1] = ~ring1_n;
    assign raw_src[SRC_RI2] = ~ring2_n;
    assign raw_src[SRC_KBD] = ~kbd_data;
    assign raw_src[SRC_MOUSE] = ~mouse_data;
    assign raw_src[SRC_KEY] = key_match;
    assign raw_src[SRC_FAN_TACH] = fan_tach_edge;
    assign raw_src[SRC_GPIO] = gpio_wake_in;
    assign raw_src[SRC_RETAINED] = retained_config_pin_in;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            src_last_reg <= '0;
        end else begin
            src_meta_reg <= raw_src;
            src_sync_reg <= src_meta_reg;
            src_last_reg <= src_sync_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {div_clk_reg, slow_clock_input_pin, 1'b0};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // nonwake pins are deliberately left unconnected to the wake logic
    logic nonwake_unused;
    assign nonwake_unused = nonwake_pin_a_in ^ nonwake_pin_b_in ^ nonwake_pin_c_in;

    assign src_rise = src_sync_reg & ~src_last_reg;

    // key and tach wake need a running slow clock
    always_comb begin
        status_clear = '0;
        if (reg_wr && bus_ok && reg_addr == WAKE_STATUS_OFS) begin
            status_clear = reg_wdata;
        end
    end

    function automatic logic [WAKE_SOURCES-1:0] gated_rise(input logic [WAKE_SOURCES-1:0] r);
        logic [WAKE_SOURCES-1:0] g;
        g = r;
        if (!slow_functions_run) begin
            g[SRC_KEY] = 1'b0;
            g[SRC_FAN_TACH] = 1'b0;
        end
        return g;
    endfunction : gated_rise

    // sticky wake status, set beats clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wake_status_reg <= '0;
        end else begin
            wake_status_reg <= (wake_status_reg & ~status_clear) | gated_rise(src_rise);
        end
    end

    // wake output, open drain
    assign wake_event_out_n_o = 1'b0;
    assign wake_event_out_n_oe = |(wake_status_reg & wake_enable_reg);

    // internal slow clock divider from the 14 MHz tick
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_cnt_reg <= 16'h0000;
            div_clk_reg <= 1'b0;
        end else if (fast_clk_tick && main_power_valid) begin
            if (div_cnt_reg == 16'(DIV_HALF - 1)) begin
                div_cnt_reg <= 16'h0000;
                div_clk_reg <= ~div_clk_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_last_reg <= 1'b0;
        end else begin
            div_last_reg <= absent ? pin_sync_reg[2] : pin_sync_reg[1];
        end
    end

    assign ext_tick = pin_sync_reg[1] & ~div_last_reg;
    assign int_tick = pin_sync_reg[2] & ~div_last_reg;
    assign slow_functions_run = !absent || main_power_valid;
    assign slow_tick = slow_functions_run && (absent ? int_tick : ext_tick);

    // led blink phase on the slow clock
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            blink_phase_reg <= 1'b0;
        end else if (slow_tick) begin
            blink_phase_reg <= ~blink_phase_reg;
        end
    end

    // serial port 2 activation seen since main power-on
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !main_rst_b || !main_power_valid) begin
            main_seen_reg <= 1'b0;
        end else if (serial2_active) begin
            main_seen_reg <= 1'b1;
        end
    end

    // pin drivers
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !main_rst_b || !hard_rst_b) begin
            fan_control_pin_a <= 1'b0;
            fan_control_pin_b <= 1'b0;
        end else if (!main_power_valid) begin
            fan_control_pin_a <= fan_a_drive;
            fan_control_pin_b <= fan_b_drive;
        end else begin
            fan_control_pin_a <= fan_a_drive;
            fan_control_pin_b <= fan_b_drive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !main_rst_b || !hard_rst_b || !main_power_valid || !main_seen_reg) begin
            alt_infrared_tx_pin <= 1'b0;
            primary_infrared_tx_pin <= 1'b0;
        end else begin
            alt_infrared_tx_pin <= serial2_txd;
            primary_infrared_tx_pin <= serial2_txd;
        end
    end

    logic retained_level;
    always_comb begin
        retained_level = retained_gpio_drive;
        if (main_power_valid && pin_config_reg[CFG_ALT_BIT]) begin
            retained_level = retained_alt_drive;
        end
        if (!main_power_valid) begin
            retained_level = retained_gpio_drive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            retained_config_pin_o <= 1'b0;
            retained_config_pin_oe <= 1'b0;
        end else begin
            retained_config_pin_o <= retained_level ^ pin_config_reg[CFG_INV_BIT];
            retained_config_pin_oe <= pin_config_reg[CFG_DIR_BIT] && main_power_valid
                && !(pin_config_reg[CFG_OD_BIT] && (retained_level ^ pin_config_reg[CFG_INV_BIT]));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            led_pin_one <= 1'b0;
            led_pin_two <= 1'b0;
        end else begin
            led_pin_one <= led_one_on && (!led_blink || blink_phase_reg);
            led_pin_two <= led_two_on && (!led_blink || blink_phase_reg);
        end
    end

    property p_wake_low;
        @(posedge clk_sys) disable iff (!rst_b)
        (|(wake_status_reg & wake_enable_reg)) |-> wake_event_out_n_oe;
    endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake not asserted");
    property p_wake_idle;
        @(posedge clk_sys) disable iff (!rst_b)
        (wake_status_reg == '0) |-> !wake_event_out_n_oe;
    endproperty
    a_wake_idle: assert property (p_wake_idle) else $error("wake asserted idle");
    sequence s_ring_rise;
        src_sync_reg[SRC_RI1] && !src_last_reg[SRC_RI1];
    endsequence
    property p_set_wins;
        @(posedge clk_sys) disable iff (!rst_b)
        s_ring_rise |=> wake_status_reg[SRC_RI1];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("ring event lost");
    property p_ir_low;
        @(posedge clk_sys) disable iff (!rst_b)
        !main_power_valid |=> !alt_infrared_tx_pin && !primary_infrared_tx_pin;
    endproperty
    a_ir_low: assert property (p_ir_low) else $error("ir not low");
    property p_fan_reset;
        @(posedge clk_sys)
        !hard_rst_b || !main_rst_b |=> !fan_control_pin_a && !fan_control_pin_b;
    endproperty
    a_fan_reset: assert property (p_fan_reset) else $error("fan not low");
    property p_pres_write;
        @(posedge clk_sys) disable iff (!rst_b)
        reg_wr && bus_ok && reg_addr == SLOW_CLOCK_PRESENCE_OFS |=>
        presence_reg == {7'h00, $past(reg_wdata[ABSENT_BIT])};
    endproperty
    a_pres_write: assert property (p_pres_write) else $error("presence write");
    property p_bus_off;
        @(posedge clk_sys) disable iff (!rst_b)
        !main_power_valid |-> reg_rdata == 8'h00;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus decoded");
    property p_slow_stop;
        @(posedge clk_sys) disable iff (!rst_b)
        absent && !main_power_valid |-> !slow_tick;
    endproperty
    a_slow_stop: assert property (p_slow_stop) else $error("slow tick running");
    property p_keep;
        @(posedge clk_sys) disable iff (!rst_b)
        !main_rst_b |=> $stable(presence_reg) || $past(reg_wr);
    endproperty
    a_keep: assert property (p_keep) else $error("presence lost");
endmodule : tpw_core

// ### common/tpw_pkg.sv
// tpw_pkg: constants for the trickle power wake and slow clock select block
// assumes one 100 MHz system clock and a simple 8-bit register port
package tpw_pkg;
    localparam logic [7:0] SLOW_CLOCK_PRESENCE_OFS = 8'hf0;
    localparam logic [7:0] WAKE_STATUS_OFS = 8'hf1;
    localparam logic [7:0] WAKE_ENABLE_OFS = 8'hf2;
    localparam logic [7:0] PIN_CONFIG_OFS = 8'hf3;
    localparam int ABSENT_BIT = 0;
    localparam logic [7:0] PRESENCE_RESET = 8'h00;
    localparam logic [7:0] WAKE_ENABLE_RESET = 8'h00;
    localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
    localparam int CFG_DIR_BIT = 0;
    localparam int CFG_INV_BIT = 1;
    localparam int CFG_OD_BIT = 2;
    localparam int CFG_ALT_BIT = 3;
    localparam int FAST_CLOCK_HZ = 14318180;
    localparam int SLOW_CLOCK_HZ = 32768;
    localparam int SLOW_DIV_HALF = FAST_CLOCK_HZ / (2 * SLOW_CLOCK_HZ);
    localparam int WAKE_SOURCES = 8;
    localparam int SRC_RI1 = 0;
    localparam int SRC_RI2 = 1;
    localparam int SRC_KBD = 2;
    localparam int SRC_MOUSE = 3;
    localparam int SRC_KEY = 4;
    localparam int SRC_FAN_TACH = 5;
    localparam int SRC_GPIO = 6;
    localparam int SRC_RETAINED = 7;
endpackage : tpw_pkg

// ### test/tpw_chipset_model.sv
// tpw_chipset_model: chipset side of the open-drain wake line
// assumes a pull-up on the wake line; samples it on clk_sys
`timescale 1ns/1ps
module tpw_chipset_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wake_event_out_n_o,
    input wire logic wake_event_out_n_oe,
    output logic wake_line,
    output logic wake_seen
);
    // pull-up holds the line high when nobody drives it
    assign wake_line = wake_event_out_n_oe ? wake_event_out_n_o : 1'b1;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wake_seen <= 1'b0;
        end else begin
            wake_seen <= !wake_line;
        end
    end
endmodule : tpw_chipset_model

// ### test/tb.sv
// tb: self-checking bench for tpw_core
// assumes 100 MHz clk_sys, a fast divider of 2 and a chipset model on the wake line
`timescale 1ns/1ps
module tb;
    import tpw_pkg::*;
    localparam int SIM_DIV_HALF = 2;
    logic clk_sys = 0, rst_b = 0, main_rst_b = 0, hard_rst_b = 0, pwr = 1;
    logic reg_wr = 0, reg_rd = 0, s2a = 0, s2t = 0, fa = 0, fb = 0, ra = 0, rg = 0;
    logic l1 = 0, l2 = 0, lb = 0;
    logic [7:0] addr = 0, wd = 0, src = 0, rdata, v;
    logic [2:0] nw = 0;
    logic [15:0] cyc = 0;
    logic tick, run, wo, woe, pa, pb, ro, roe, ir_alt, ir_pri, led1, led2, wline, wseen;
    int num_errors = 0, compares = 0, n1, n2;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 16'h1;
        if (cyc == 16'h2000) begin
            num_errors++;
            print_verdict();
        end
    end
    tpw_core #(.DIV_HALF(SIM_DIV_HALF)) tpw_core_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .main_rst_b(main_rst_b), .hard_rst_b(hard_rst_b), .main_power_valid(pwr),
        .fast_clk_tick(cyc[0]), .slow_clock_input_pin(cyc[4]), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdata),
        .ring1_n(~src[0]), .ring2_n(~src[1]), .kbd_data(~src[2]), .mouse_data(~src[3]),
        .key_match(src[4]), .fan_tach_edge(src[5]), .gpio_wake_in(src[6]),
        .retained_config_pin_in(src[7]), .nonwake_pin_a_in(nw[0]), .nonwake_pin_b_in(nw[1]),
        .nonwake_pin_c_in(nw[2]), .fan_a_drive(fa), .fan_b_drive(fb),
        .retained_alt_drive(ra), .retained_gpio_drive(rg), .serial2_active(s2a),
        .serial2_txd(s2t), .led_one_on(l1), .led_two_on(l2), .led_blink(lb),
        .slow_tick(tick), .slow_functions_run(run), .wake_event_out_n_o(wo),
        .wake_event_out_n_oe(woe), .fan_control_pin_a(pa), .fan_control_pin_b(pb),
        .retained_config_pin_o(ro), .retained_config_pin_oe(roe),
        .alt_infrared_tx_pin(ir_alt), .primary_infrared_tx_pin(ir_pri),
        .led_pin_one(led1), .led_pin_two(led2));
    tpw_chipset_model tpw_chipset_model_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .wake_event_out_n_o(wo), .wake_event_out_n_oe(woe), .wake_line(wline),
        .wake_seen(wseen));
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1;
        addr = a;
        wd = d;
        step(1);
        reg_wr = 0;
        wd = ~d;
        step(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd = 1;
        addr = a;
        #2 d = rdata;
        step(1);
        reg_rd = 0;
        step(1);
    endtask : rd
    task automatic count_ticks(output int n);
        n = 0;
        repeat (64) begin
            step(1);
            n += int'(tick === 1'b1);
        end
    endtask : count_ticks
    task automatic test_reset_and_clock();
        rd(SLOW_CLOCK_PRESENCE_OFS, v);
        check("presence_reset", v, PRESENCE_RESET);
        check("pins_reset", {4'h0, pa, pb, ir_alt, ir_pri}, 8'h00);
        count_ticks(n1);
        wr(SLOW_CLOCK_PRESENCE_OFS, 8'h01);
        rd(SLOW_CLOCK_PRESENCE_OFS, v);
        check("presence_set", v, 8'h01);
        count_ticks(n2);
        check("tick_ext", 8'(n1), 8'h02);
        check("tick_int", 8'(n2), 8'(64 / (4 * SIM_DIV_HALF)));
        pwr = 0;
        step(3);
        check("run_off", {7'h0, run}, 8'h00);
        pwr = 1;
        step(3);
        check("run_on", {7'h0, run}, 8'h01);
        fa = 1;
        fb = 1;
        main_rst_b = 0;
        step(2);
        check("fan_after", {6'h0, pa, pb}, 8'h00);
        main_rst_b = 1;
        hard_rst_b = 0;
        step(2);
        check("fan_hard_rst", {6'h0, pa, pb}, 8'h00);
        hard_rst_b = 1;
        fa = 0;
        fb = 0;
        step(1);
        rd(SLOW_CLOCK_PRESENCE_OFS, v);
        check("presence_keep", v, 8'h01);
        rst_b = 0;
        step(2);
        rst_b = 1;
        step(1);
        rd(SLOW_CLOCK_PRESENCE_OFS, v);
        check("presence_por", v, 8'h00);
    endtask : test_reset_and_clock
    task automatic test_wake();
        for (int i = 0; i < WAKE_SOURCES; i++) begin
            wr(WAKE_ENABLE_OFS, 8'h01 << i);
            pwr = 0;
            nw = 3'h7;
            step(4);
            check("nonwake", {7'h0, wline}, 8'h01);
            src[i] = 1;
            for (int k = 0; k < 8 && wline !== 1'b0; k++) step(1);
            check("wake_low", {7'h0, wline}, 8'h00);
            step(1);
            check("wake_seen", {7'h0, wseen}, 8'h01);
            src[i] = 0;
            nw = 3'h0;
            pwr = 1;
            step(4);
            rd(WAKE_STATUS_OFS, v);
            check("status", v, 8'h01 << i);
            wr(WAKE_STATUS_OFS, 8'hff);
            step(2);
            check("wake_rel", {7'h0, wline}, 8'h01);
        end
        wr(WAKE_ENABLE_OFS, 8'h00); // all enables cleared before every source is driven
        src = 8'hff;
        step(6);
        check("disabled", {7'h0, wline}, 8'h01);
        src = 8'h00;
        step(4);
        wr(WAKE_STATUS_OFS, 8'hff);
        wr(SLOW_CLOCK_PRESENCE_OFS, 8'h01);
        wr(WAKE_ENABLE_OFS, 8'h30);
        pwr = 0;
        src = 8'h30;
        step(6);
        check("key_stop", {7'h0, wline}, 8'h01);
        src = 8'h00;
        step(4);
        pwr = 1;
        step(1);
        rd(WAKE_STATUS_OFS, v);
        check("key_status", v, 8'h00);
        wr(WAKE_ENABLE_OFS, 8'h00);
        wr(SLOW_CLOCK_PRESENCE_OFS, 8'h00);
    endtask : test_wake
    task automatic test_pins();
        pwr = 0;
        wr(WAKE_ENABLE_OFS, 8'hff);
        pwr = 1;
        rd(WAKE_ENABLE_OFS, v);
        check("bus_off", v, 8'h00);
        s2t = 1;
        step(3);
        check("ir_idle", {6'h0, ir_alt, ir_pri}, 8'h00);
        s2a = 1;
        step(3);
        check("ir_follow", {6'h0, ir_alt, ir_pri}, 8'h03);
        wr(PIN_CONFIG_OFS, 8'h0b);
        rg = 1;
        fa = 1;
        l1 = 1;
        step(2);
        check("retained_alt", {6'h0, roe, ro}, 8'h03);
        pwr = 0;
        step(3);
        check("ir_nopwr", {6'h0, ir_alt, ir_pri}, 8'h00);
        check("fan_gpio", {6'h0, pa, pb}, 8'h02);
        check("retained", {6'h0, roe, ro}, 8'h00);
        check("led", {6'h0, led1, led2}, 8'h02);
        pwr = 1;
        step(2);
        rd(PIN_CONFIG_OFS, v);
        check("config_kept", v, 8'h0b);
    endtask : test_pins
    task automatic print_verdict();
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        step(2);
        rst_b = 1;
        main_rst_b = 1;
        hard_rst_b = 1;
        step(1);
        test_reset_and_clock();
        test_wake();
        test_pins();
        print_verdict();
    end
endmodule : tb
